// *** vdpg_pkg.sv ***
// package for the voltage-code decode and pulse gating core
// assumes a single 100 MHz clock and an Avalon-MM register slave
//
// Notes on behaviour
// - intervals are timed from the clock, one switching period each
// - at interval start the pulse stays low while error level is below ramp
// - pulse low keeps the upper switch off and the lower switch on
// - error level crossing the ramp drives the pulse high, upper switch on
// - pulse stays high until the second crossing, then returns low
// - at most one rising edge per interval, further rises wait
// - a fast-response trip event forces the pulse high like a ramp crossing, unless the code means off
// - strap low picks 8-bit table, strap high picks 5 or 6-bit by top bit
// - 8-bit codes 0 and 1 mean off, code 2 highest, then lower steps
// - undriven code bits read high in 8-bit mode, low otherwise
package vdpg_pkg;

   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned SWITCH_HZ_DFLT   = 1_000_000;
   localparam int unsigned PERIOD_CYC_DFLT  = CLK_HZ / SWITCH_HZ_DFLT;
   localparam int unsigned PERIOD_CYC_MIN   = 4;

   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_COUNT  = 4'h8;

   localparam int unsigned CTRL_RUN_BIT    = 0;
   localparam int unsigned CTRL_TRIPEN_BIT = 1;
   localparam int unsigned CTRL_PER_LSB    = 16;
   localparam logic        CTRL_RUN_RST    = 1'b1;
   localparam logic        CTRL_TRIPEN_RST = 1'b1;

   localparam int unsigned ST_PULSE_BIT = 0;
   localparam int unsigned ST_OFF_BIT   = 1;
   localparam int unsigned ST_EN_BIT    = 2;
   localparam int unsigned ST_MODE_LSB  = 4;
   localparam int unsigned ST_CODE_LSB  = 8;
   localparam int unsigned ST_STEP_LSB  = 16;

   localparam logic [7:0] OFF_CODE_LAST = 8'h01;
   localparam logic [7:0] FIRST_STEP    = 8'h02;
   localparam logic [7:0] MASK_5BIT     = 8'h1F;
   localparam logic [7:0] MASK_6BIT     = 8'h3F;

   typedef enum logic [2:0]
   {
      VDPG_TBL_8BIT = 3'b001,
      VDPG_TBL_5BIT = 3'b010,
      VDPG_TBL_6BIT = 3'b100
   } vdpg_table_t;

   typedef enum logic [2:0]
   {
      VDPG_ARMED = 3'b001,
      VDPG_HIGH  = 3'b010,
      VDPG_SPENT = 3'b100
   } vdpg_state_t;

endpackage : vdpg_pkg

// *** vdpg_sync.sv ***
// two-flop synchroniser bank for pins arriving from outside the clock
// assumes each bit is an independent level
`timescale 1ns/1ps
`default_nettype none
module vdpg_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_sys_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         meta_q <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : vdpg_sync
`default_nettype wire

// *** vdpg_interval.sv ***
// interval timer: one-cycle start pulse every period_i clock cycles
// assumes period_i is at least the package minimum
`timescale 1ns/1ps
`default_nettype none
module vdpg_interval #(
   parameter int unsigned CNT_W = 16
) (
   input  wire logic             clk_sys_i,
   input  wire logic             nrst_i,
   input  wire logic             run_i,
   input  wire logic [CNT_W-1:0] period_i,
   output var  logic             start_o
);
   logic [CNT_W-1:0] cnt_q;
   wire              wrap = (cnt_q >= period_i - CNT_W'(1));

   // elaboration-time refusal of a counter too narrow to time an interval
   if (CNT_W < 3)
   begin : g_bad_width
      $error("vdpg_interval: counter too narrow");
   end

   // a new period value takes effect at once, mid-interval; a count already at or past it wraps on the next cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i || !run_i)
      begin
         cnt_q   <= '0;
         start_o <= 1'b0;
      end
      else
      begin
         cnt_q   <= wrap ? '0 : cnt_q + CNT_W'(1);
         start_o <= wrap;
      end
   end
endmodule : vdpg_interval
`default_nettype wire

// *** vdpg_core.sv ***
// voltage-code decode, interval timing and pulse gating core
// assumes analog comparators and pins are asynchronous and pass two flops;
// register access is an Avalon-MM slave with waitrequest on the same clock
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module vdpg_core #(
   parameter int unsigned PERIOD_DFLT = vdpg_pkg::PERIOD_CYC_DFLT
) (
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   // pins
   input  wire logic [7:0]  voltage_code_input_i,
   input  wire logic [7:0]  voltage_code_driven_i,
   input  wire logic        softstart_strap_high_i,
   input  wire logic        enable_pin_i,
   input  wire logic        error_above_ramp_i,
   input  wire logic        fast_response_trigger_i,
   // outputs toward the switch drivers and reference
   output var  logic        pulse_o,
   output var  logic        upper_switch_on_o,
   output var  logic        lower_switch_on_o,
   output var  logic [7:0]  reference_level_o,
   output var  logic        output_off_o,
   output var  logic [2:0]  table_mode_o,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output var  logic [31:0] avs_readdata_o,
   output var  logic        avs_waitrequest_o
);

   // elaboration-time refusal of a period the 16-bit timer cannot serve
   if (PERIOD_DFLT < vdpg_pkg::PERIOD_CYC_MIN || PERIOD_DFLT > 65535)
   begin : g_bad_period
      $error("vdpg_core: period default out of range");
   end

   localparam logic [15:0] PER_RST = 16'(PERIOD_DFLT);

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [19:0] pins_s;

   vdpg_sync #(
      .WIDTH (20)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .async_i   ({voltage_code_input_i, voltage_code_driven_i,
                   softstart_strap_high_i, enable_pin_i,
                   error_above_ramp_i, fast_response_trigger_i}),
      .sync_o    (pins_s)
   );

   wire [7:0] code_pin_s   = pins_s[19:12];
   wire [7:0] code_drv_s   = pins_s[11:4];
   wire       strap_high_s = pins_s[3];
   wire       enable_s     = pins_s[2];
   wire       above_ramp_s = pins_s[1];
   wire       trip_s       = pins_s[0];

   // ------------------------------------------------------------------
   // decode functions
   // ------------------------------------------------------------------
   // undriven pins follow the weak pull of the active mode
   function automatic logic [7:0] resolve_code(
      input logic [7:0] pin,
      input logic [7:0] drv,
      input logic       pull_high
   );
      resolve_code = (pin & drv) | ({8{pull_high}} & ~drv);
   endfunction : resolve_code

   function automatic vdpg_pkg::vdpg_table_t pick_table(
      input logic strap_high,
      input logic top_bit
   );
      if (!strap_high)
         pick_table = vdpg_pkg::VDPG_TBL_8BIT;
      else if (top_bit)
         pick_table = vdpg_pkg::VDPG_TBL_5BIT;
      else
         pick_table = vdpg_pkg::VDPG_TBL_6BIT;
   endfunction : pick_table

   // ------------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------------
   logic        run_q;
   logic        trip_en_q;
   logic [15:0] period_q;
   logic [15:0] pulse_cnt_q;
   logic [15:0] trip_cnt_q;

   // ------------------------------------------------------------------
   // code decode
   // ------------------------------------------------------------------
   // strap low means pull-ups are active, so undriven bits read high
   wire pull_high = !strap_high_s;
   wire [7:0] code_res = resolve_code(code_pin_s, code_drv_s, pull_high);
   wire vdpg_pkg::vdpg_table_t table_d =
      pick_table(strap_high_s, code_res[7]);
   wire tbl8 = (table_d == vdpg_pkg::VDPG_TBL_8BIT);
   wire tbl5 = (table_d == vdpg_pkg::VDPG_TBL_5BIT);

   // only the 8-bit table has off codes; step 0 is the highest level
   wire off_d = tbl8 && (code_res <= vdpg_pkg::OFF_CODE_LAST);
   wire [7:0] step_d =
      tbl8 ? (off_d ? 8'h00 : code_res - vdpg_pkg::FIRST_STEP) :
      tbl5 ? (code_res & vdpg_pkg::MASK_5BIT) :
             (code_res & vdpg_pkg::MASK_6BIT);

   logic [7:0] code_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         reference_level_o <= 8'h00;
         output_off_o      <= 1'b1;
         table_mode_o      <= vdpg_pkg::VDPG_TBL_8BIT;
         code_q            <= 8'h00;
      end
      else
      begin
         reference_level_o <= step_d;
         output_off_o      <= off_d;
         table_mode_o      <= table_d;
         code_q            <= code_res;
      end
   end

   // ------------------------------------------------------------------
   // interval timer
   // ------------------------------------------------------------------
   wire active = run_q && enable_s;
   logic interval_start;

   vdpg_interval #(
      .CNT_W (16)
   ) u_interval (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .run_i     (active),
      .period_i  (period_q),
      .start_o   (interval_start)
   );

   // ------------------------------------------------------------------
   // pulse gating state machine
   // ------------------------------------------------------------------
   vdpg_pkg::vdpg_state_t state_q;
   vdpg_pkg::vdpg_state_t state_d;

   // trips are ignored while the code means off
   wire trip_ok  = trip_s && trip_en_q && !output_off_o;
   wire rise_req = above_ramp_s || trip_ok;
   wire hold_off = !active || output_off_o;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         vdpg_pkg::VDPG_ARMED:
         begin
            if (rise_req)
               state_d = vdpg_pkg::VDPG_HIGH;
         end
         vdpg_pkg::VDPG_HIGH:
         begin
            // a forced pulse ends with the trip and the ramp both clear
            if (!above_ramp_s && !trip_ok)
               state_d = interval_start ? vdpg_pkg::VDPG_ARMED
                                        : vdpg_pkg::VDPG_SPENT;
         end
         vdpg_pkg::VDPG_SPENT:
         begin
            if (interval_start)
               state_d = vdpg_pkg::VDPG_ARMED;
         end
         default:
            state_d = vdpg_pkg::VDPG_SPENT;
      endcase
      // new interval: armed, and low unless the level is already above
      if (interval_start && state_q == vdpg_pkg::VDPG_SPENT && rise_req)
         state_d = vdpg_pkg::VDPG_HIGH;
      if (hold_off)
         state_d = vdpg_pkg::VDPG_SPENT;
   end

   wire pulse_d = (state_d == vdpg_pkg::VDPG_HIGH);
   wire rising  = pulse_d && !pulse_o;

   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         state_q           <= vdpg_pkg::VDPG_SPENT;
         pulse_o           <= 1'b0;
         upper_switch_on_o <= 1'b0;
         lower_switch_on_o <= 1'b1;
      end
      else
      begin
         state_q           <= state_d;
         pulse_o           <= pulse_d;
         upper_switch_on_o <= pulse_d;
         lower_switch_on_o <= !pulse_d;
      end
   end

   // free-running event counters, wrap silently
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         pulse_cnt_q <= 16'h0000;
         trip_cnt_q  <= 16'h0000;
      end
      else
      begin
         if (rising)
            pulse_cnt_q <= pulse_cnt_q + 16'h0001;
         if (rising && trip_ok && !above_ramp_s)
            trip_cnt_q <= trip_cnt_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------------
   // avalon-mm slave: waitrequest high on first cycle, low on the second
   // ------------------------------------------------------------------
   wire req      = avs_read_i || avs_write_i;
   wire first    = req && avs_waitrequest_o;
   wire commit   = req && !avs_waitrequest_o;
   wire hit_ctrl = (avs_address_i == vdpg_pkg::OFS_CTRL);
   wire hit_st   = (avs_address_i == vdpg_pkg::OFS_STATUS);
   wire hit_cnt  = (avs_address_i == vdpg_pkg::OFS_COUNT);
   wire wr_ctrl  = commit && avs_write_i && hit_ctrl;

   wire [31:0] ctrl_word = {period_q, 14'h0000, trip_en_q, run_q};
   wire [31:0] st_word   = {8'h00, reference_level_o, code_q,
                            1'b0, table_mode_o, 1'b0, enable_s,
                            output_off_o, pulse_o};
   wire [31:0] cnt_word  = {trip_cnt_q, pulse_cnt_q};
   // unmapped addresses read zero and ignore writes
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl_word :
      hit_st   ? st_word   :
      hit_cnt  ? cnt_word  : 32'h0000_0000;

   wire [15:0] per_wr = avs_writedata_i[vdpg_pkg::CTRL_PER_LSB +: 16];
   wire        per_ok = (per_wr >= 16'(vdpg_pkg::PERIOD_CYC_MIN));

   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest_o <= !first;
         if (first && avs_read_i)
            avs_readdata_o <= rd_mux;
      end
   end

   // too short a period is refused so the timer always has room
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         run_q     <= vdpg_pkg::CTRL_RUN_RST;
         trip_en_q <= vdpg_pkg::CTRL_TRIPEN_RST;
         period_q  <= PER_RST;
      end
      else if (wr_ctrl)
      begin
         if (avs_byteenable_i[0])
         begin
            run_q     <= avs_writedata_i[vdpg_pkg::CTRL_RUN_BIT];
            trip_en_q <= avs_writedata_i[vdpg_pkg::CTRL_TRIPEN_BIT];
         end
         if (&avs_byteenable_i[3:2] && per_ok)
            period_q <= per_wr;
      end
   end

endmodule : vdpg_core
`default_nettype wire

// *** vdpg_cpu_model.sv ***
// model of the processor that presents the voltage code
// assumes the bench picks the code, the drive mask and the pull family
`timescale 1ns/1ps
`default_nettype none
module vdpg_cpu_model (
   input  wire logic       pull_high_i,
   input  wire logic [7:0] code_i,
   input  wire logic [7:0] oe_i,
   output var  logic [7:0] pin_o,
   output var  logic [7:0] driven_o
);
   // released bits settle to the weak pull, never to a stale level
   assign pin_o    = (code_i & oe_i) | ({8{pull_high_i}} & ~oe_i);
   // logic swing only, so the pull-up voltage limit is never exceeded
   assign driven_o = oe_i;
endmodule : vdpg_cpu_model
`default_nettype wire

// *** vdpg_monitor.sv ***
// checker for the code decode and pulse gating core
// assumes it is bound to vdpg_core and pins pass two flops plus a register
`timescale 1ns/1ps
`default_nettype none
module vdpg_monitor (
   input wire logic       clk_sys_i,
   input wire logic       nrst_i,
   input wire logic [7:0] voltage_code_input_i,
   input wire logic [7:0] voltage_code_driven_i,
   input wire logic       softstart_strap_high_i,
   input wire logic       error_above_ramp_i,
   input wire logic       fast_response_trigger_i,
   input wire logic       pulse_o,
   input wire logic       upper_switch_on_o,
   input wire logic       lower_switch_on_o,
   input wire logic [7:0] reference_level_o,
   input wire logic       output_off_o,
   input wire logic [2:0] table_mode_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   logic [2:0] age_q;
   logic       settled;
   logic [7:0] res8;
   logic [7:0] res56;
   // decoded outputs only mean something once the pipeline has flushed
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
         age_q <= 3'h0;
      else if (age_q != 3'h4)
         age_q <= age_q + 3'h1;
   end
   assign settled = (age_q == 3'h4);
   assign res8    = voltage_code_input_i | ~voltage_code_driven_i;
   assign res56   = voltage_code_input_i & voltage_code_driven_i;

   AST_LOWER_INV: assert property (lower_switch_on_o == !pulse_o)
      else $error("lower switch not inverse of pulse");
   AST_UPPER_PULSE: assert property (upper_switch_on_o == pulse_o)
      else $error("upper switch differs from pulse");
   AST_RISE_CAUSE: assert property ($rose(pulse_o) |->
      $past(error_above_ramp_i, 3) || $past(fast_response_trigger_i, 3))
      else $error("pulse rose without a cause");
   AST_OFF_QUIET: assert property (
      output_off_o && $past(output_off_o) |-> !pulse_o)
      else $error("pulse high while code means off");
   AST_TABLE_8: assert property (
      settled && !$past(softstart_strap_high_i, 3)
      |-> table_mode_o == vdpg_pkg::VDPG_TBL_8BIT)
      else $error("strap low did not pick the 8-bit table");
   AST_TABLE_56: assert property (
      settled && $past(softstart_strap_high_i, 3) |-> table_mode_o ==
      ($past(res56[7], 3) ? vdpg_pkg::VDPG_TBL_5BIT : vdpg_pkg::VDPG_TBL_6BIT))
      else $error("wrong 5/6-bit table pick");
   AST_OFF_8: assert property (
      settled && !$past(softstart_strap_high_i, 3)
      |-> output_off_o == ($past(res8, 3) <= 8'h01))
      else $error("off decode wrong in 8-bit table");
   AST_STEP_8: assert property (
      settled && !$past(softstart_strap_high_i, 3) && !output_off_o
      |-> reference_level_o == $past(res8, 3) - 8'h02)
      else $error("8-bit step wrong");
   AST_STEP_56: assert property (settled &&
      $past(softstart_strap_high_i, 3) |-> !output_off_o && reference_level_o
      == ($past(res56, 3) & ($past(res56[7], 3) ? 8'h1F : 8'h3F)))
      else $error("5/6-bit step wrong");

   cover property ($rose(pulse_o));
   cover property (output_off_o && fast_response_trigger_i);
   cover property (table_mode_o == vdpg_pkg::VDPG_TBL_5BIT);
endmodule : vdpg_monitor

bind vdpg_core vdpg_monitor u_monitor (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
   .voltage_code_input_i(voltage_code_input_i),
   .voltage_code_driven_i(voltage_code_driven_i),
   .softstart_strap_high_i(softstart_strap_high_i),
   .error_above_ramp_i(error_above_ramp_i),
   .fast_response_trigger_i(fast_response_trigger_i),
   .pulse_o(pulse_o), .upper_switch_on_o(upper_switch_on_o),
   .lower_switch_on_o(lower_switch_on_o),
   .reference_level_o(reference_level_o), .output_off_o(output_off_o),
   .table_mode_o(table_mode_o)
);
`default_nettype wire

// *** vdpg_core_test.sv ***
// self-checking bench for the code decode and pulse gating core
// assumes the cpu model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module vdpg_core_test;
   typedef struct packed {
      logic strap; logic [7:0] code; logic [7:0] oe;
      logic [2:0] mode; logic off; logic [7:0] step;
   } vdpg_row_t;
   localparam vdpg_row_t ROWS [12] = '{
      '{1'b0, 8'h02, 8'hFF, 3'h1, 1'b0, 8'h00},
      '{1'b0, 8'h00, 8'hFF, 3'h1, 1'b1, 8'h00},
      '{1'b0, 8'h01, 8'hFF, 3'h1, 1'b1, 8'h00},
      '{1'b0, 8'h03, 8'hFF, 3'h1, 1'b0, 8'h01},
      '{1'b0, 8'hFF, 8'hFF, 3'h1, 1'b0, 8'hFD},
      '{1'b0, 8'h00, 8'hFE, 3'h1, 1'b1, 8'h00},
      '{1'b0, 8'h02, 8'h00, 3'h1, 1'b0, 8'hFD},
      '{1'b1, 8'h80, 8'hFF, 3'h2, 1'b0, 8'h00},
      '{1'b1, 8'h9F, 8'hFF, 3'h2, 1'b0, 8'h1F},
      '{1'b1, 8'h3F, 8'hFF, 3'h4, 1'b0, 8'h3F},
      '{1'b1, 8'hFF, 8'h7F, 3'h4, 1'b0, 8'h3F},
      '{1'b1, 8'h00, 8'hFF, 3'h4, 1'b0, 8'h00}};
   logic clk_sys_i = 1'b0, nrst_i = 1'b0, strap = 1'b0, err = 1'b0;
   logic trip = 1'b0, rd_q = 1'b0, wr_q = 1'b0;
   logic [7:0] code = 8'h02, oe = 8'hFF, pin, drv, lvl;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0000_0000, rdata, seen;
   logic pulse, upper, lower, off, waitreq;
   logic [2:0] mode;
   int mismatches = 0, checks = 0, cyc_cnt = 0, t1;
   always #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) cyc_cnt <= cyc_cnt + 1;
   vdpg_cpu_model u_cpu (.pull_high_i(!strap), .code_i(code), .oe_i(oe),
      .pin_o(pin), .driven_o(drv));
   // shorter period keeps the interval tests brief
   vdpg_core #(.PERIOD_DFLT(16)) u_dut (.clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i), .voltage_code_input_i(pin),
      .voltage_code_driven_i(drv), .softstart_strap_high_i(strap),
      .enable_pin_i(1'b1), .error_above_ramp_i(err),
      .fast_response_trigger_i(trip), .pulse_o(pulse),
      .upper_switch_on_o(upper), .lower_switch_on_o(lower),
      .reference_level_o(lvl), .output_off_o(off), .table_mode_o(mode),
      .avs_address_i(adr), .avs_read_i(rd_q), .avs_write_i(wr_q),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq));
   task automatic wrap_up();
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : cyc
   // outputs are read at the edge, before that edge's updates land
   task automatic wait_pulse(input logic want);
      for (int i = 0; i < 40 && pulse !== want; i++) cyc(1);
      chk("pulse", want, pulse);
      if (pulse !== want)
         wrap_up();
   endtask : wait_pulse
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [31:0] exp);
      int i;
      cyc(1);
      rd_q <= !w;
      wr_q <= w;
      adr <= a;
      wd <= d;
      for (i = 0; i < 20; i++)
      begin
         cyc(1);
         if (waitreq === 1'b0)
            break;
      end
      seen = rdata;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      chk("bus_wait", 1'b0, waitreq);
      if (i == 20)
         wrap_up();
      if (!w)
         chk("readdata", exp, seen);
   endtask : bus
   initial
   begin
      cyc(20);
      nrst_i <= 1'b1;
      cyc(4);
      foreach (ROWS[k])
      begin
         strap <= ROWS[k].strap;
         code <= ROWS[k].code;
         oe <= ROWS[k].oe;
         cyc(6);
         chk("table", ROWS[k].mode, mode);
         chk("off", ROWS[k].off, off);
         if (!ROWS[k].off)
            chk("step", ROWS[k].step, lvl);
      end
      strap <= 1'b0;
      code <= 8'h02;
      bus(1'b0, 4'h0, 32'h0, 32'h0010_0003);
      bus(1'b0, 4'hC, 32'h0, 32'h0000_0000);
      bus(1'b1, 4'h0, 32'h0008_0003, 32'h0);
      bus(1'b1, 4'h0, 32'h0002_0003, 32'h0);
      bus(1'b0, 4'h0, 32'h0, 32'h0008_0003);
      err <= 1'b1;
      wait_pulse(1'b1);
      chk("upper", 1'b1, upper);
      chk("lower", 1'b0, lower);
      err <= 1'b0;
      wait_pulse(1'b0);
      chk("lower_low", 1'b1, lower);
      err <= 1'b1;
      wait_pulse(1'b1);
      t1 = cyc_cnt;
      err <= 1'b0;
      wait_pulse(1'b0);
      err <= 1'b1;
      wait_pulse(1'b1);
      chk("interval", 32'h0000_0008, cyc_cnt - t1);
      err <= 1'b0;
      wait_pulse(1'b0);
      cyc(10);
      trip <= 1'b1;
      wait_pulse(1'b1);
      trip <= 1'b0;
      wait_pulse(1'b0);
      bus(1'b0, 4'h8, 32'h0, 32'h0001_0004);
      code <= 8'h00;
      cyc(6);
      err <= 1'b1;
      trip <= 1'b1;
      repeat (20)
      begin
         cyc(1);
         chk("pulse_off", 1'b0, pulse);
      end
      err <= 1'b0;
      trip <= 1'b0;
      nrst_i <= 1'b0;
      cyc(3);
      chk("rst_pulse", 1'b0, pulse);
      chk("rst_lower", 1'b1, lower);
      chk("rst_upper", 1'b0, upper);
      chk("rst_table", 3'h1, mode);
      chk("rst_off", 1'b1, off);
      chk("rst_wait", 1'b1, waitreq);
      nrst_i <= 1'b1;
      bus(1'b0, 4'h0, 32'h0, 32'h0010_0003);
      wrap_up();
   end
endmodule : vdpg_core_test
`default_nettype wire
